/* err_detect_defines.svh */
// constants for the converter error detection block
`ifndef ERR_DETECT_DEFINES_SVH
`define ERR_DETECT_DEFINES_SVH
// ==========================================================
// timing and short test line numbers
`define CLK_MHZ 50
`define MASK_TIME_US 26000
`define WIN0_TIME_US 1000
`define WIN1_TIME_US 2000
`define WIN2_TIME_US 4000
`define WIN3_TIME_US 7370
`define SHORT_SLOT_US 13
`define SHORT_LINES 6
`define SHORT_LAST_LINE 3'h5
`define SHORT_FIRST_INPUT 3'h2
// ==========================================================
// register byte offsets
`define OFS_THR 8'h00
`define OFS_CTL 8'h04
`define OFS_SEL 8'h08
`define OFS_AMP 8'h0c
`define OFS_STS 8'h10
`define OFS_LAT 8'h14
// ==========================================================
// field positions, select reset value and start method code
`define THR_DP 0
`define THR_CNT 4
`define CTL_EN 0
`define CTL_CLR 1
`define CTL_WIN 2
`define CTL_CIRC 4
`define CTL_MODE 5
`define CTL_EXC 6
`define CTL_METH 8
`define CTL_START 10
`define CTL_AMPCLR 11
`define CTL_MASKED 12
`define AMP_LO 0
`define AMP_HI 16
`define SEL_RESET 15'h7fff
`define METH_WRITE 2'h1
// ==========================================================
// cause bit positions
`define C_CONV 0
`define C_DUAL 1
`define C_PWR 2
`define C_GND 8
`define C_AMP 14
// ==========================================================
// arithmetic
`define AMP_SHIFT 4
`define DP_LIMIT_BASE 16'h0008
`endif

/* err_detect_pkg.sv */
// types for the converter error detection block
`include "err_detect_defines.svh"
package err_detect_pkg;
    typedef logic [15:0] angle_t;
    typedef logic signed [11:0] mon_t;
    typedef logic [5:0] lines_t;
    typedef enum logic {st_idle, st_test} short_state_t;
    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        logic [1:0] dp_thr;
        logic [2:0] cnt_thr;
        logic det_en;
        logic [1:0] win_sel;
        logic circ_sel;
        logic conv_mode;
        logic int_exc;
        logic [1:0] st_method;
        logic [14:0] cause_sel;
        logic [15:0] amp_lo;
        logic [15:0] amp_hi;
        logic [23:0] mask_cnt;
        logic mask_done;
        logic [15:0] half_len;
        logic [15:0] half_hi;
        logic half_phase;
        logic [23:0] win_cnt;
        logic [15:0] abn_halves;
        logic [15:0] tot_halves;
        logic conv_res;
        short_state_t sst;
        logic [2:0] line_idx;
        logic [9:0] slot_cnt;
        logic disc;
        lines_t pwr_res;
        lines_t gnd_res;
        lines_t pwr_s1;
        lines_t pwr_s2;
        lines_t gnd_s1;
        lines_t gnd_s2;
        logic [31:0] acc;
        logic [7:0] amp_cnt;
        logic [14:0] live;
        logic [14:0] latched;
        logic hold;
        logic summary;
        logic irq;
    } state_t;
endpackage : err_detect_pkg

/* resolver_converter_error_detection.sv */
// error detection logic of the resolver converter with its avalon register slave
`timescale 1ns/100ps
`include "err_detect_defines.svh"
module resolver_converter_error_detection #(
    parameter int MASK_CYC = `MASK_TIME_US * `CLK_MHZ,
    parameter int WIN0_CYC = `WIN0_TIME_US * `CLK_MHZ,
    parameter int WIN1_CYC = `WIN1_TIME_US * `CLK_MHZ,
    parameter int WIN2_CYC = `WIN2_TIME_US * `CLK_MHZ,
    parameter int WIN3_CYC = `WIN3_TIME_US * `CLK_MHZ
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic out_of_range_signal,
    input wire logic excite_half_tick,
    input wire logic excite_period_tick,
    input wire err_detect_pkg::angle_t angle_path0,
    input wire err_detect_pkg::angle_t angle_path1,
    input wire err_detect_pkg::mon_t sine_monitor,
    input wire err_detect_pkg::mon_t cosine_monitor,
    input wire logic monitor_valid,
    input wire err_detect_pkg::lines_t power_short_level,
    input wire err_detect_pkg::lines_t ground_short_level,
    output logic input_disconnect,
    output logic [2:0] test_line_sel,
    output logic conv_error_irq
);
    import err_detect_pkg::*;

    localparam int SLOT_CYC = `SHORT_SLOT_US * `CLK_MHZ;

    state_t state_ff;
    state_t nxt_state;

    logic wr_taken;
    logic clr;
    logic start_req;
    logic cnt_clr;
    logic [31:0] w_thr;
    logic [31:0] w_ctl;
    logic [31:0] w_sel;
    logic [31:0] w_amp;
    logic [31:0] w_new;
    logic [14:0] cond;
    logic [14:0] live;
    logic [14:0] live_x;
    logic [15:0] adiff;
    logic [15:0] dsub;
    logic dp_err;
    logic judge;
    logic abn;
    logic win_end;
    logic slot_end;
    logic line_ok;
    logic [22:0] sq_sum;
    logic [31:0] integ;

    // ==========================================================
    // helpers
    function automatic logic [31:0] merge_be(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_be

    function automatic logic [21:0] sq12(input mon_t v);
        logic signed [23:0] p;
        p = v * v;
        return p[21:0];
    endfunction : sq12

    function automatic logic [23:0] win_len(input logic [1:0] sel);
        case (sel)
            2'h0: return 24'(WIN0_CYC);
            2'h1: return 24'(WIN1_CYC);
            2'h2: return 24'(WIN2_CYC);
            default: return 24'(WIN3_CYC);
        endcase
    endfunction : win_len

    function automatic logic [15:0] dp_limit(input logic [1:0] thr);
        return `DP_LIMIT_BASE << thr;
    endfunction : dp_limit

    // ==========================================================
    // next state
    always_comb begin
        nxt_state = state_ff;

        // bus slave: one wait state, effects at the edge waitrequest is seen low
        wr_taken = write & ~state_ff.waitreq;
        nxt_state.waitreq = ~(state_ff.waitreq & (read | write));
        w_thr = 32'h0;
        w_thr[`THR_DP +: 2] = state_ff.dp_thr;
        w_thr[`THR_CNT +: 3] = state_ff.cnt_thr;
        w_ctl = 32'h0;
        w_ctl[`CTL_EN] = state_ff.det_en;
        w_ctl[`CTL_WIN +: 2] = state_ff.win_sel;
        w_ctl[`CTL_CIRC] = state_ff.circ_sel;
        w_ctl[`CTL_MODE] = state_ff.conv_mode;
        w_ctl[`CTL_EXC] = state_ff.int_exc;
        w_ctl[`CTL_METH +: 2] = state_ff.st_method;
        w_ctl[`CTL_START] = state_ff.disc;
        w_ctl[`CTL_MASKED] = state_ff.mask_done;
        w_sel = {17'h0, state_ff.cause_sel};
        w_amp = 32'h0;
        w_amp[`AMP_LO +: 16] = state_ff.amp_lo;
        w_amp[`AMP_HI +: 16] = state_ff.amp_hi;
        if (state_ff.waitreq && read) begin
            case (address)
                `OFS_THR: nxt_state.rdata = w_thr;
                `OFS_CTL: nxt_state.rdata = w_ctl;
                `OFS_SEL: nxt_state.rdata = w_sel;
                `OFS_AMP: nxt_state.rdata = w_amp;
                `OFS_STS: nxt_state.rdata = {15'h0, state_ff.live, state_ff.hold,
                                             state_ff.summary};
                `OFS_LAT: nxt_state.rdata = {state_ff.amp_cnt, 9'h0, state_ff.latched};
                default: nxt_state.rdata = 32'h0;
            endcase
        end
        w_new = 32'h0;
        if (wr_taken) begin
            case (address)
                `OFS_THR: begin
                    w_new = merge_be(w_thr, writedata, byteenable);
                    nxt_state.dp_thr = w_new[`THR_DP +: 2];
                    nxt_state.cnt_thr = w_new[`THR_CNT +: 3];
                end
                `OFS_CTL: begin
                    w_new = merge_be(w_ctl, writedata, byteenable);
                    nxt_state.det_en = w_new[`CTL_EN];
                    nxt_state.win_sel = w_new[`CTL_WIN +: 2];
                    nxt_state.circ_sel = w_new[`CTL_CIRC];
                    nxt_state.conv_mode = w_new[`CTL_MODE];
                    nxt_state.int_exc = w_new[`CTL_EXC];
                    nxt_state.st_method = w_new[`CTL_METH +: 2];
                end
                `OFS_SEL: begin
                    w_new = merge_be(w_sel, writedata, byteenable);
                    nxt_state.cause_sel = w_new[14:0];
                end
                `OFS_AMP: begin
                    w_new = merge_be(w_amp, writedata, byteenable);
                    nxt_state.amp_lo = w_new[`AMP_LO +: 16];
                    nxt_state.amp_hi = w_new[`AMP_HI +: 16];
                end
                default: w_new = 32'h0;
            endcase
        end
        clr = wr_taken && address == `OFS_CTL && byteenable[0] && writedata[`CTL_CLR];
        start_req = wr_taken && address == `OFS_CTL && byteenable[1]
                    && writedata[`CTL_START];
        cnt_clr = wr_taken && address == `OFS_CTL && byteenable[1]
                  && writedata[`CTL_AMPCLR];

        // output mask after enable; dropping enable restarts the wait
        if (!state_ff.det_en) begin
            nxt_state.mask_cnt = 24'h0;
            nxt_state.mask_done = 1'b0;
        end else if (!state_ff.mask_done) begin
            if (state_ff.mask_cnt == 24'(MASK_CYC - 1)) begin
                nxt_state.mask_done = 1'b1;
            end else begin
                nxt_state.mask_cnt = state_ff.mask_cnt + 24'h1;
            end
        end

        // conversion error: judge half periods, then the window
        nxt_state.half_len = state_ff.half_len + 16'h1;
        nxt_state.half_hi = state_ff.half_hi + {15'h0, out_of_range_signal};
        // variant 1 judges whole periods, slower to react at high speed
        judge = excite_half_tick && (!state_ff.circ_sel || state_ff.half_phase);
        abn = 1'b0;
        if (excite_half_tick) begin
            nxt_state.half_phase = ~state_ff.half_phase;
        end
        if (judge) begin
            abn = {state_ff.half_hi, 1'b0} > {1'b0, state_ff.half_len};
            nxt_state.half_len = 16'h0;
            nxt_state.half_hi = 16'h0;
        end
        win_end = state_ff.win_cnt >= win_len(state_ff.win_sel) - 24'h1;
        if (win_end) begin
            nxt_state.conv_res = {state_ff.abn_halves, 1'b0}
                                 > {1'b0, state_ff.tot_halves};
            nxt_state.win_cnt = 24'h0;
            nxt_state.abn_halves = {15'h0, abn};
            nxt_state.tot_halves = {15'h0, judge};
        end else begin
            nxt_state.win_cnt = state_ff.win_cnt + 24'h1;
            nxt_state.abn_halves = state_ff.abn_halves + {15'h0, abn};
            nxt_state.tot_halves = state_ff.tot_halves + {15'h0, judge};
        end

        // two path comparison, wrap-around difference
        dsub = angle_path0 - angle_path1;
        adiff = dsub[15] ? 16'h0 - dsub : dsub;
        if (state_ff.conv_mode) begin
            dp_err = adiff != 16'h0;
        end else begin
            dp_err = adiff > dp_limit(state_ff.dp_thr);
        end

        // short test sequence
        nxt_state.pwr_s1 = power_short_level;
        nxt_state.pwr_s2 = state_ff.pwr_s1;
        nxt_state.gnd_s1 = ground_short_level;
        nxt_state.gnd_s2 = state_ff.gnd_s1;
        slot_end = state_ff.sst == st_test && state_ff.slot_cnt == 10'(SLOT_CYC - 1);
        // driver fights a short on excitation and common lines
        line_ok = !(state_ff.int_exc && state_ff.line_idx < `SHORT_FIRST_INPUT);
        case (state_ff.sst)
            st_idle: begin
                if (start_req && state_ff.st_method == `METH_WRITE) begin
                    nxt_state.sst = st_test;
                    nxt_state.line_idx = 3'h0;
                    nxt_state.slot_cnt = 10'h0;
                    nxt_state.disc = 1'b1;
                end
            end
            st_test: begin
                nxt_state.slot_cnt = state_ff.slot_cnt + 10'h1;
                if (slot_end) begin
                    nxt_state.pwr_res[state_ff.line_idx] =
                        state_ff.pwr_s2[state_ff.line_idx] & line_ok;
                    nxt_state.gnd_res[state_ff.line_idx] =
                        state_ff.gnd_s2[state_ff.line_idx] & line_ok;
                    nxt_state.slot_cnt = 10'h0;
                    if (state_ff.line_idx == `SHORT_LAST_LINE) begin
                        nxt_state.sst = st_idle;
                        nxt_state.disc = 1'b0;
                        nxt_state.line_idx = 3'h0;
                    end else begin
                        nxt_state.line_idx = state_ff.line_idx + 3'h1;
                    end
                end
            end
            default: nxt_state.sst = st_idle;
        endcase

        // sum of squares, integrated over each excitation period
        sq_sum = {1'b0, sq12(sine_monitor)} + {1'b0, sq12(cosine_monitor)};
        integ = state_ff.acc >> `AMP_SHIFT;
        if (monitor_valid) begin
            nxt_state.acc = state_ff.acc + {9'h0, sq_sum};
        end
        if (excite_period_tick) begin
            nxt_state.acc = monitor_valid ? {9'h0, sq_sum} : 32'h0;
            if ((integ > {16'h0, state_ff.amp_hi} || integ < {16'h0, state_ff.amp_lo})
                && state_ff.amp_cnt != 8'hff) begin
                nxt_state.amp_cnt = state_ff.amp_cnt + 8'h1;
            end
        end
        if (cnt_clr) begin
            nxt_state.amp_cnt = 8'h0;
        end

        // flags: live level, sticky copies; a set beats a clear
        cond = {state_ff.amp_cnt > {5'h0, state_ff.cnt_thr}, state_ff.gnd_res,
                state_ff.pwr_res, dp_err, state_ff.conv_res};
        live = cond & ~state_ff.cause_sel & {15{state_ff.mask_done}};
        live_x = live;
        live_x[`C_CONV] = live[`C_CONV] | (|live[`C_PWR+5:`C_PWR+2])
                          | (|live[`C_GND+5:`C_GND+2]);
        nxt_state.live = live_x;
        nxt_state.latched = (state_ff.latched & ~{15{clr}}) | live_x;
        nxt_state.hold = (state_ff.hold & ~clr) | (|live_x);
        nxt_state.summary = |live_x;
        nxt_state.irq = |live_x;
    end

    // ==========================================================
    // state register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_ff <= '0;
            state_ff.waitreq <= 1'b1;
            state_ff.cause_sel <= `SEL_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign readdata = state_ff.rdata;
    assign waitrequest = state_ff.waitreq;
    assign input_disconnect = state_ff.disc;
    assign test_line_sel = state_ff.line_idx;
    assign conv_error_irq = state_ff.irq;

    // ==========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    chk_mask_blocks: assert property (!state_ff.mask_done |=> !state_ff.summary)
        else $error("flag reported while masked");
    chk_mask_time: assert property ($rose(state_ff.mask_done)
        |-> $past(state_ff.det_en) && state_ff.mask_cnt == 24'(MASK_CYC - 1))
        else $error("mask released at wrong count");
    chk_clear_persist: assert property (clr && live_x[`C_CONV]
        |=> state_ff.latched[`C_CONV] && state_ff.hold)
        else $error("persisting error lost on clear");
    chk_conv_flags: assert property (live_x[`C_CONV]
        |=> state_ff.latched[`C_CONV] && state_ff.hold && state_ff.summary
            && state_ff.live[`C_CONV])
        else $error("conversion flags not set");
    chk_dual_thr: assert property (state_ff.mask_done && !state_ff.cause_sel[`C_DUAL]
        && !state_ff.conv_mode && state_ff.dp_thr == 2'h2 && adiff == 16'h0021
        |=> state_ff.latched[`C_DUAL] && state_ff.hold)
        else $error("dual path limit 32 not enforced");
    chk_mode1_lsb: assert property (state_ff.mask_done && !state_ff.cause_sel[`C_DUAL]
        && state_ff.conv_mode && adiff == 16'h0001 |=> state_ff.live[`C_DUAL])
        else $error("one lsb difference missed");
    chk_select_off: assert property (state_ff.cause_sel[`C_DUAL]
        && !state_ff.latched[`C_DUAL] |=> !state_ff.latched[`C_DUAL])
        else $error("deselected cause set a flag");
    chk_short_start: assert property (start_req && state_ff.st_method == `METH_WRITE
        && state_ff.sst == st_idle |=> state_ff.disc && state_ff.line_idx == 3'h0)
        else $error("short test did not start");
    chk_short_end: assert property ($fell(state_ff.disc)
        |-> $past(state_ff.line_idx) == `SHORT_LAST_LINE
            && $past(state_ff.slot_cnt) == 10'(SLOT_CYC - 1))
        else $error("short test length wrong");
    chk_slot_step: assert property (slot_end && state_ff.line_idx != `SHORT_LAST_LINE
        |=> state_ff.line_idx == $past(state_ff.line_idx) + 3'h1 && state_ff.disc)
        else $error("line slot did not advance");
    chk_exc_skip: assert property (slot_end && state_ff.int_exc && state_ff.line_idx == 3'h0
        |=> !state_ff.pwr_res[0] && !state_ff.gnd_res[0])
        else $error("excitation line judged under internal excitation");
    chk_amp_error: assert property (state_ff.mask_done && !state_ff.cause_sel[`C_AMP]
        && state_ff.amp_cnt > {5'h0, state_ff.cnt_thr} |=> state_ff.latched[`C_AMP])
        else $error("amplitude error not flagged");
    chk_irq_level: assert property (|live_x |=> state_ff.irq ##1 1'b1)
        else $error("interrupt request not raised");

    cov_mask_release: cover property ($rose(state_ff.mask_done));
    cov_conv_error: cover property ($rose(state_ff.latched[`C_CONV]));
    cov_short_done: cover property ($fell(state_ff.disc));
    cov_amp_error: cover property ($rose(state_ff.latched[`C_AMP]));
endmodule : resolver_converter_error_detection

/* rdc_front_model.sv */
// resolver front end model driving the error detection inputs
`timescale 1ns/100ps
module rdc_front_model (
    input wire logic clock,
    input wire logic resetn,
    input wire logic input_disconnect,
    input wire logic oor,
    input wire err_detect_pkg::angle_t diff,
    input wire err_detect_pkg::lines_t gshort,
    input wire err_detect_pkg::lines_t pshort,
    output logic out_of_range_signal,
    output logic excite_half_tick,
    output logic excite_period_tick,
    output err_detect_pkg::angle_t angle_path0,
    output err_detect_pkg::angle_t angle_path1,
    output err_detect_pkg::mon_t sine_monitor,
    output err_detect_pkg::mon_t cosine_monitor,
    output logic monitor_valid,
    output err_detect_pkg::lines_t power_short_level,
    output err_detect_pkg::lines_t ground_short_level
);
    import err_detect_pkg::*;
    // ==========================================
    // excitation timing, 40 cycle period
    logic [5:0] phase_ff;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            phase_ff <= 6'h00;
            angle_path0 <= 16'h0000;
        end else begin
            phase_ff <= (phase_ff == 6'h27) ? 6'h00 : phase_ff + 6'h01;
            angle_path0 <= angle_path0 + 16'h0003;
        end
    end
    assign excite_half_tick = (phase_ff == 6'h13) || (phase_ff == 6'h27);
    assign excite_period_tick = (phase_ff == 6'h27);
    assign angle_path1 = angle_path0 + diff;
    assign monitor_valid = (phase_ff[1:0] == 2'h3);
    // ==========================================
    // monitors: junk between samples, common while cut off
    assign sine_monitor = !monitor_valid ? {6'h00, phase_ff}
                        : input_disconnect ? 12'sh000 : 12'sh100;
    assign cosine_monitor = !monitor_valid ? {6'h3f, ~phase_ff}
                          : input_disconnect ? 12'sh000 : 12'sh0c0;
    assign out_of_range_signal = oor;
    assign power_short_level = pshort;
    assign ground_short_level = gshort;
endmodule : rdc_front_model

/* tb_top.sv */
// self-checking bench for the converter error detection block
`timescale 1ns/100ps
module tb_top;
    import err_detect_pkg::*;
    logic clock, resetn, read, write, oor, input_disconnect, conv_error_irq, waitrequest;
    logic [7:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [2:0] test_line_sel;
    logic out_of_range_signal, excite_half_tick, excite_period_tick, monitor_valid;
    angle_t diff, angle_path0, angle_path1;
    mon_t sine_monitor, cosine_monitor;
    lines_t gshort, pshort, power_short_level, ground_short_level;
    logic [3:0] be;
    int fails, samples_checked, n;
    // ==========================================
    // instances, counts shortened for simulation
    resolver_converter_error_detection #(.MASK_CYC(100), .WIN0_CYC(200), .WIN1_CYC(200),
        .WIN2_CYC(200), .WIN3_CYC(200)) u_resolver_converter_error_detection (
        .clock(clock), .resetn(resetn), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(be), .readdata(readdata),
        .waitrequest(waitrequest), .out_of_range_signal(out_of_range_signal),
        .excite_half_tick(excite_half_tick), .excite_period_tick(excite_period_tick),
        .angle_path0(angle_path0), .angle_path1(angle_path1), .sine_monitor(sine_monitor),
        .cosine_monitor(cosine_monitor), .monitor_valid(monitor_valid),
        .power_short_level(power_short_level), .ground_short_level(ground_short_level),
        .input_disconnect(input_disconnect), .test_line_sel(test_line_sel),
        .conv_error_irq(conv_error_irq));
    rdc_front_model u_rdc_front_model (.clock(clock), .resetn(resetn),
        .input_disconnect(input_disconnect), .oor(oor), .diff(diff), .gshort(gshort),
        .pshort(pshort),
        .out_of_range_signal(out_of_range_signal), .excite_half_tick(excite_half_tick),
        .excite_period_tick(excite_period_tick), .angle_path0(angle_path0),
        .angle_path1(angle_path1), .sine_monitor(sine_monitor),
        .cosine_monitor(cosine_monitor), .monitor_valid(monitor_valid),
        .power_short_level(power_short_level), .ground_short_level(ground_short_level));
    // ==========================================
    // bus, compare and closing tasks
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask : bus
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    // limit 8<<v in mode 0, any difference in mode 1
    function automatic logic dual_exp(input angle_t d, input logic [1:0] v, input logic m);
        dual_exp = m ? (d != 16'h0000) : (d > (16'h0008 << v));
    endfunction : dual_exp
    // ==========================================
    // clock, watchdog, test sequence
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        repeat (40000) @(posedge clock);
        fails++;
        summarize();
    end
    initial begin
        resetn = 1'b0;
        {read, write, oor} = 3'h0;
        address = 8'h00;
        writedata = 32'h0;
        diff = 16'h0000;
        gshort = 6'h00;
        pshort = 6'h00;
        be = 4'hf;
        fails = 0;
        samples_checked = 0;
        void'($urandom(32'h60d2));
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        bus(0, 8'h08, 0); chk(rd, 32'h7fff);
        bus(0, 8'h04, 0); chk(rd, 32'h0);
        bus(0, 8'h20, 0); chk(rd, 32'h0);
        // amplitude window set in two lane-masked writes
        be <= 4'h3;
        bus(1, 8'h0c, 32'h0000c350);
        be <= 4'hc;
        bus(1, 8'h0c, 32'hfde8ffff);
        be <= 4'hf;
        bus(0, 8'h0c, 0); chk(rd, 32'hfde8c350);
        bus(1, 8'h00, 32'h2);
        bus(1, 8'h08, 32'h0);
        diff <= 16'h0028;
        bus(1, 8'h04, 32'h80d);
        bus(0, 8'h10, 0); chk(rd[3], 1'b0);
        repeat (84) @(posedge clock);
        bus(0, 8'h04, 0); chk(rd[12], 1'b0);
        repeat (15) @(posedge clock);
        bus(0, 8'h04, 0); chk(rd[12], 1'b1);
        bus(0, 8'h10, 0); chk(rd[3:0], 4'hb);
        chk(conv_error_irq, 1'b1);
        bus(1, 8'h04, 32'hf);
        bus(0, 8'h14, 0); chk(rd[1], 1'b1);
        for (int i = 0; i < 8; i++) begin
            diff <= (i == 0) ? 16'd32 : (i == 1) ? 16'd33 : 16'($urandom_range(64));
            repeat (3) @(posedge clock);
            bus(0, 8'h10, 0); chk(rd[3], dual_exp(diff, 2'h2, 1'b0));
        end
        diff <= 16'h0001;
        bus(1, 8'h04, 32'h2d);
        repeat (3) @(posedge clock);
        bus(0, 8'h10, 0); chk(rd[3], dual_exp(16'h0001, 2'h2, 1'b1));
        diff <= 16'h0000;
        bus(1, 8'h04, 32'hf);
        bus(0, 8'h14, 0); chk(rd[14:0], 15'h0);
        bus(1, 8'h08, 32'h2);
        diff <= 16'h0028;
        repeat (3) @(posedge clock);
        bus(0, 8'h10, 0); chk(rd[3], 1'b0);
        diff <= 16'h0000;
        bus(1, 8'h08, 32'h0);
        oor <= 1'b1;
        repeat (450) @(posedge clock);
        bus(0, 8'h10, 0); chk(rd[2], 1'b1);
        bus(0, 8'h14, 0); chk(rd[0], 1'b1);
        oor <= 1'b0;
        repeat (450) @(posedge clock);
        bus(0, 8'h10, 0); chk(rd[2], 1'b0);
        // method 0 must not start a test
        gshort <= 6'h05;
        pshort <= 6'h08;
        bus(1, 8'h04, 32'h40f);
        repeat (3) @(posedge clock);
        chk(input_disconnect, 1'b0);
        // start method must stand before the start write
        bus(1, 8'h04, 32'h10d);
        bus(1, 8'h04, 32'h50d);
        n = 0;
        while (input_disconnect !== 1'b1 && n < 10) begin
            @(posedge clock);
            n++;
        end
        n = 0;
        while (input_disconnect === 1'b1 && n < 5000) begin
            @(posedge clock);
            n++;
        end
        chk(n, 32'd3900);
        bus(0, 8'h14, 0); chk(rd[10], 1'b1);
        chk(rd[8], 1'b1);
        chk(rd[5], 1'b1);
        chk(rd[14], 1'b1);
        bus(0, 8'h10, 0); chk(rd[2], 1'b1);
        chk(input_disconnect, 1'b0);
        // let the periods spoilt by the cut pass before clearing the count
        repeat (80) @(posedge clock);
        bus(1, 8'h04, 32'h90d);
        bus(0, 8'h14, 0); chk(rd[31:24], 8'h00);
        // internal excitation hides shorts on the excitation line
        bus(1, 8'h04, 32'h54d);
        repeat (3910) @(posedge clock);
        bus(0, 8'h10, 0); chk(rd[10], 1'b0);
        chk(rd[12], 1'b1);
        summarize();
    end
endmodule : tb_top
